// [hdl/digitizer_control_defines.svh]
// constants for the digitizer control pin block
`ifndef DIGITIZER_CONTROL_DEFINES_SVH
`define DIGITIZER_CONTROL_DEFINES_SVH

// oscillator and feedback divider
`define NOM_INC       16'h8000
`define TERM_COUNT    12'd320
`define HALF_TERM     12'd160
`define FB_PULSE_LEN  12'd16
`define GAIN_SHIFT    2
// lock detection
`define LOCK_TOL      13'sd4
`define LOCK_EDGES    3'd4
// display line sync delay in clock cycles
`define DISPLAY_SYNC_DELAY 4
// formatter mode codes
`define MODE_BUS_A    2'h0
`define MODE_BUS_AB   2'h1
`define MODE_OFF      2'h2
// synchroniser reset level: chip reset asserted, all pins low
`define SYNC_RESET    9'h000

`endif

// [hdl/digitizer_control_pkg.sv]
// types shared by the digitizer control pin block
package digitizer_control_pkg;

  typedef enum logic [2:0] {
    LK_UNLOCKED = 3'b001,
    LK_ACQUIRE  = 3'b010,
    LK_LOCKED   = 3'b100
  } lock_state_t;

  typedef logic [1:0] formatter_mode_setting_t;

  // pin levels after synchronisation
  typedef struct packed {
    logic scan_test;
    logic oe_n;
    logic chip_reset_n;
    logic sync_slice;
    logic ch1_slice;
    logic phase_detector_hold;
    logic clamp_pulse;
    logic frame_sync;
    logic line_sync;
  } pins_t;

  typedef struct packed {
    logic [23:0] data;
    logic        oe;
  } bus_t;

endpackage

// [hdl/pin_sync.sv]
// two-flop synchroniser for asynchronous pins
`timescale 1ns/10ps
`include "digitizer_control_defines.svh"

module pin_sync #(
  parameter int WIDTH = 9
) (
  input  wire logic             clk_in,
  input  wire logic             arst_n_in,
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] meta;

  if (WIDTH < 1)
  begin
    $error("pin_sync width must be at least one");
  end

  // first stage feeds only the second stage
  always_ff @(posedge clk_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
    begin
      meta     <= WIDTH'(`SYNC_RESET);
      sync_out <= WIDTH'(`SYNC_RESET);
    end
    else
    begin
      meta     <= async_in;
      sync_out <= meta;
    end
  end

endmodule

// [hdl/digitizer_control_pins.sv]
// control pins of the video digitizer: sync inputs, digital pll, lock, output enables
//
// Function
// - line sync is the pll reference, polarity set by line_sync_polarity.
// - frame sync input polarity is set by frame_sync_polarity.
// - display line sync is delayed line sync or feedback divider pulse.
// - composite sync comes from channel one slicer or dedicated slicer input.
// - lock output low while unlocked, high when locked.
// - hold input freezes phase detector and keeps last oscillator increment.
// - each bus drives only when enable low and formatter mode uses it.
// - an inactive data bus still carries data, with its oe low.
// - clock output keeps running whatever the output enable.
// - chip reset is active low and acts on master clock edges.
// - while hold is asserted, line sync edges give no phase update.
`timescale 1ns/10ps
`include "digitizer_control_defines.svh"

module digitizer_control_pins
  import digitizer_control_pkg::*;
#(
  parameter int SYNC_DELAY = `DISPLAY_SYNC_DELAY
) (
  input  wire logic                    CLK_IN,
  input  wire logic                    ARST_N_IN,
  input  wire logic                    CHIP_RESET_N_IN,
  input  wire logic                    LINE_SYNC_IN,
  input  wire logic                    FRAME_SYNC_IN,
  input  wire logic                    CLAMP_PULSE_IN,
  input  wire logic                    PHASE_DETECTOR_HOLD_IN,
  input  wire logic                    CH1_SLICE_IN,
  input  wire logic                    SYNC_SLICE_IN,
  input  wire logic                    OE_N_IN,
  input  wire logic                    SCAN_TEST_IN,
  input  wire logic                    LINE_SYNC_POLARITY_IN,
  input  wire logic                    FRAME_SYNC_POLARITY_IN,
  input  wire logic                    SYNC_FROM_DIVIDER_IN,
  input  wire logic                    CSYNC_FROM_INPUT_IN,
  input  wire formatter_mode_setting_t FORMATTER_MODE_SETTING_IN,
  input  wire logic [23:0]             BUS_A_DATA_IN,
  input  wire logic [23:0]             BUS_B_DATA_IN,
  output bus_t                         BUS_A_OUT,
  output bus_t                         BUS_B_OUT,
  output logic                         DISPLAY_LINE_SYNC_OUT,
  output logic                         COMPOSITE_SYNC_OUT,
  output logic                         FRAME_SYNC_OUT,
  output logic                         CLAMP_WINDOW_OUT,
  output logic                         LOCK_OUT,
  output logic                         PIXEL_CLOCK_OUT,
  output logic                         SCAN_ACTIVE_OUT
);

  if (SYNC_DELAY < 1 || SYNC_DELAY > 64)
  begin
    $error("SYNC_DELAY must lie in 1..64");
  end

  // ----------------------------------------
  // pin synchronisers
  // ----------------------------------------
  pins_t pins_raw;
  pins_t pins;

  assign pins_raw = '{scan_test: SCAN_TEST_IN, oe_n: OE_N_IN, chip_reset_n: CHIP_RESET_N_IN,
                      sync_slice: SYNC_SLICE_IN, ch1_slice: CH1_SLICE_IN,
                      phase_detector_hold: PHASE_DETECTOR_HOLD_IN,
                      clamp_pulse: CLAMP_PULSE_IN, frame_sync: FRAME_SYNC_IN,
                      line_sync: LINE_SYNC_IN};

  pin_sync #(.WIDTH($bits(pins_t))) u_sync (
    .clk_in    (CLK_IN),
    .arst_n_in (ARST_N_IN),
    .async_in  (pins_raw),
    .sync_out  (pins)
  );

  // ----------------------------------------
  // decode
  // ----------------------------------------
  // chip reset is a plain synchronous term, so it needs running clock edges
  wire chip_rst   = ~pins.chip_reset_n;
  wire hold       = pins.phase_detector_hold;
  wire line_act   = pins.line_sync ~^ LINE_SYNC_POLARITY_IN;
  wire frame_act  = pins.frame_sync ~^ FRAME_SYNC_POLARITY_IN;
  wire bus_a_used = FORMATTER_MODE_SETTING_IN != `MODE_OFF;
  wire bus_b_used = FORMATTER_MODE_SETTING_IN == `MODE_BUS_AB;

  logic                  line_prev;
  logic [SYNC_DELAY-1:0] line_dly;
  logic [15:0]           osc_inc;
  logic [15:0]           osc_acc;
  logic                  tick;
  logic [11:0]           fb_count;
  logic [2:0]            good_edges;
  lock_state_t           lock_state;

  wire ref_edge = line_act & ~line_prev;
  // no reference edge is taken in chip reset, so reset cannot fake an update
  wire take_ref = ref_edge & ~hold & ~chip_rst;
  wire fb_pulse = fb_count < `FB_PULSE_LEN;

  // phase error: positive when the divider wrapped before the reference edge
  wire signed [12:0] err = (fb_count < `HALF_TERM) ? $signed({1'b0, fb_count})
                                                   : $signed({1'b0, fb_count} - {1'b0, `TERM_COUNT});
  wire signed [15:0] err_ext  = 16'(err);
  wire        [15:0] next_inc = 16'(`NOM_INC - 16'(err_ext <<< `GAIN_SHIFT));
  wire               err_ok   = (err <= `LOCK_TOL) && (err >= -`LOCK_TOL);
  wire        [16:0] acc_sum  = {1'b0, osc_acc} + {1'b0, osc_inc};

  // ----------------------------------------
  // digital oscillator and feedback divider
  // ----------------------------------------
  always_ff @(posedge CLK_IN or negedge ARST_N_IN)
  begin
    if (!ARST_N_IN)
    begin
      osc_inc  <= `NOM_INC;
      osc_acc  <= 16'h0000;
      tick     <= 1'b0;
      fb_count <= 12'h000;
    end
    else if (chip_rst)
    begin
      osc_inc  <= `NOM_INC;
      osc_acc  <= 16'h0000;
      tick     <= 1'b0;
      fb_count <= 12'h000;
    end
    else
    begin
      if (take_ref)
        osc_inc <= next_inc;
      osc_acc <= acc_sum[15:0];
      tick    <= acc_sum[16];
      if (tick)
        fb_count <= (fb_count == `TERM_COUNT - 12'h001) ? 12'h000 : fb_count + 12'h001;
    end
  end

  // ----------------------------------------
  // lock detection
  // ----------------------------------------
  lock_state_t next_lock;
  logic [2:0]  next_good;

  always_comb
  begin
    next_lock = lock_state;
    next_good = good_edges;
    if (take_ref)
    begin
      unique case (lock_state)
        LK_UNLOCKED:
        begin
          next_good = err_ok ? 3'h1 : 3'h0;
          next_lock = err_ok ? LK_ACQUIRE : LK_UNLOCKED;
        end
        LK_ACQUIRE:
        begin
          next_good = err_ok ? good_edges + 3'h1 : 3'h0;
          if (!err_ok)
            next_lock = LK_UNLOCKED;
          else if (good_edges == `LOCK_EDGES - 3'h1)
            next_lock = LK_LOCKED;
        end
        LK_LOCKED:
        begin
          next_good = err_ok ? good_edges : 3'h0;
          next_lock = err_ok ? LK_LOCKED : LK_UNLOCKED;
        end
        default:
        begin
          next_good = 3'h0;
          next_lock = LK_UNLOCKED;
        end
      endcase
    end
  end

  always_ff @(posedge CLK_IN or negedge ARST_N_IN)
  begin
    if (!ARST_N_IN)
    begin
      lock_state <= LK_UNLOCKED;
      good_edges <= 3'h0;
    end
    else if (chip_rst)
    begin
      lock_state <= LK_UNLOCKED;
      good_edges <= 3'h0;
    end
    else
    begin
      lock_state <= next_lock;
      good_edges <= next_good;
    end
  end

  // ----------------------------------------
  // outputs
  // ----------------------------------------
  // data stays on the pins even when disabled; the pad turns it off via oe
  always_ff @(posedge CLK_IN or negedge ARST_N_IN)
  begin
    if (!ARST_N_IN)
    begin
      line_prev             <= 1'b0;
      line_dly              <= '0;
      BUS_A_OUT             <= '0;
      BUS_B_OUT             <= '0;
      DISPLAY_LINE_SYNC_OUT <= 1'b0;
      COMPOSITE_SYNC_OUT    <= 1'b0;
      FRAME_SYNC_OUT        <= 1'b0;
      CLAMP_WINDOW_OUT      <= 1'b0;
      LOCK_OUT              <= 1'b0;
      PIXEL_CLOCK_OUT       <= 1'b0;
      SCAN_ACTIVE_OUT       <= 1'b0;
    end
    else if (chip_rst)
    begin
      line_prev             <= line_act;
      line_dly              <= '0;
      BUS_A_OUT             <= '0;
      BUS_B_OUT             <= '0;
      DISPLAY_LINE_SYNC_OUT <= 1'b0;
      COMPOSITE_SYNC_OUT    <= 1'b0;
      FRAME_SYNC_OUT        <= 1'b0;
      CLAMP_WINDOW_OUT      <= 1'b0;
      LOCK_OUT              <= 1'b0;
      PIXEL_CLOCK_OUT       <= 1'b0;
      SCAN_ACTIVE_OUT       <= pins.scan_test;
    end
    else
    begin
      line_prev             <= line_act;
      line_dly              <= SYNC_DELAY'({line_dly, line_act});
      BUS_A_OUT.data        <= BUS_A_DATA_IN;
      BUS_A_OUT.oe          <= ~pins.oe_n & bus_a_used;
      BUS_B_OUT.data        <= BUS_B_DATA_IN;
      BUS_B_OUT.oe          <= ~pins.oe_n & bus_b_used;
      DISPLAY_LINE_SYNC_OUT <= SYNC_FROM_DIVIDER_IN ? fb_pulse : line_dly[SYNC_DELAY-1];
      COMPOSITE_SYNC_OUT    <= CSYNC_FROM_INPUT_IN ? pins.sync_slice : pins.ch1_slice;
      FRAME_SYNC_OUT        <= frame_act;
      CLAMP_WINDOW_OUT      <= pins.clamp_pulse;
      LOCK_OUT              <= lock_state == LK_LOCKED;
      PIXEL_CLOCK_OUT       <= PIXEL_CLOCK_OUT ^ tick;
      SCAN_ACTIVE_OUT       <= pins.scan_test;
    end
  end

  // ----------------------------------------
  // assertions
  // ----------------------------------------
  default clocking cb @(posedge CLK_IN); endclocking
  default disable iff (!ARST_N_IN);

  property p_ref_polarity;
    take_ref |-> $rose(line_act) && !hold;
  endproperty
  a_ref_polarity: assert property (p_ref_polarity) else $error("reference edge wrong");

  property p_frame_pol;
    !chip_rst |=> FRAME_SYNC_OUT == ($past(pins.frame_sync) == $past(FRAME_SYNC_POLARITY_IN));
  endproperty
  a_frame_pol: assert property (p_frame_pol) else $error("frame sync polarity wrong");

  property p_dhs_source;
    !chip_rst && SYNC_FROM_DIVIDER_IN |=> DISPLAY_LINE_SYNC_OUT == $past(fb_pulse);
  endproperty
  a_dhs_source: assert property (p_dhs_source) else $error("display sync not from divider");

  property p_csync_source;
    !chip_rst && !CSYNC_FROM_INPUT_IN |=> COMPOSITE_SYNC_OUT == $past(pins.ch1_slice);
  endproperty
  a_csync_source: assert property (p_csync_source) else $error("csync source wrong");

  property p_lock_rise;
    $rose(LOCK_OUT) |-> $past(take_ref, 2) && $past(lock_state, 2) == LK_ACQUIRE
                        && $past(good_edges, 2) == `LOCK_EDGES - 3'h1;
  endproperty
  a_lock_rise: assert property (p_lock_rise) else $error("lock rose too early");

  property p_hold_freeze;
    hold && !chip_rst |=> $stable(osc_inc) && $stable(lock_state);
  endproperty
  a_hold_freeze: assert property (p_hold_freeze) else $error("update while held");

  property p_oe_off;
    OE_N_IN [*4] |=> !BUS_A_OUT.oe && !BUS_B_OUT.oe;
  endproperty
  a_oe_off: assert property (p_oe_off) else $error("bus driven while disabled");

  property p_bus_b_mode;
    BUS_B_OUT.oe |-> $past(FORMATTER_MODE_SETTING_IN) == `MODE_BUS_AB;
  endproperty
  a_bus_b_mode: assert property (p_bus_b_mode) else $error("bus b driven in wrong mode");

  property p_clock_runs;
    !chip_rst && tick |=> PIXEL_CLOCK_OUT != $past(PIXEL_CLOCK_OUT);
  endproperty
  a_clock_runs: assert property (p_clock_runs) else $error("pixel clock stalled");

  property p_chip_reset;
    chip_rst |=> !LOCK_OUT && !BUS_A_OUT.oe && !BUS_B_OUT.oe && osc_inc == `NOM_INC;
  endproperty
  a_chip_reset: assert property (p_chip_reset) else $error("chip reset ignored");

endmodule

// [test/sync_source.sv]
// line sync source model that follows the display line sync
`timescale 1ns/10ps

module sync_source (
  input  wire logic       clk_in,
  input  wire logic       track_in,
  input  wire logic       pol_in,
  input  wire logic       level_in,
  input  wire logic [9:0] lag_in,
  input  wire logic       disp_sync_in,
  output logic            line_sync_out
);
  logic disp_sync_d = 1'b0;
  int   cnt   = 1000;

  // a pulse of 20 cycles, lag cycles after each display line sync rise
  always @(posedge clk_in)
  begin
    disp_sync_d <= disp_sync_in;
    cnt = (disp_sync_in && !disp_sync_d) ? 0 : cnt + 1;
    // active level follows the programmed polarity
    line_sync_out <= track_in ? ((cnt >= lag_in && cnt < lag_in + 20) ~^ pol_in) : level_in;
  end
endmodule

// [test/tb.sv]
// self-checking bench for the digitizer control pins
`timescale 1ns/10ps
`define CHK(nm, e, g) begin checks_done++; if ((g) !== (e)) begin n_mismatch++; \
  $display("Error %s expected %h seen %h", nm, e, g); end end

module tb
  import digitizer_control_pkg::*;
;
  logic                    clk = 1'b0;
  logic                    arst_n = 1'b0, chip_rst_n = 1'b1, fs = 1'b0, clamp = 1'b0;
  logic                    hold = 1'b0, c1 = 1'b0, ss = 1'b0, oe_n = 1'b1, lpol = 1'b1;
  logic                    fpol = 1'b1, div = 1'b0, csel = 1'b0, track = 1'b0, lvl = 1'b0;
  formatter_mode_setting_t mode = 2'h0;
  logic [23:0]             da = 24'h0, db = 24'h0;
  logic [9:0]              lag = 10'h0;
  logic                    ls, dsync, csync, fso, clw, lock, pclk, scan, ea, eb, pp;
  bus_t                    ba, bb;
  logic [31:0]             rnd = 32'h3c2a00c4;
  int                      n_mismatch = 0;
  int                      checks_done = 0;
  int                      cyc = 0;

  digitizer_control_pins #(.SYNC_DELAY(2)) u_digitizer_control_pins (
    .CLK_IN(clk), .ARST_N_IN(arst_n), .CHIP_RESET_N_IN(chip_rst_n),
    .LINE_SYNC_IN(ls), .FRAME_SYNC_IN(fs), .CLAMP_PULSE_IN(clamp),
    .PHASE_DETECTOR_HOLD_IN(hold), .CH1_SLICE_IN(c1), .SYNC_SLICE_IN(ss),
    .OE_N_IN(oe_n), .SCAN_TEST_IN(1'b0), .LINE_SYNC_POLARITY_IN(lpol),
    .FRAME_SYNC_POLARITY_IN(fpol), .SYNC_FROM_DIVIDER_IN(div),
    .CSYNC_FROM_INPUT_IN(csel), .FORMATTER_MODE_SETTING_IN(mode),
    .BUS_A_DATA_IN(da), .BUS_B_DATA_IN(db), .BUS_A_OUT(ba), .BUS_B_OUT(bb),
    .DISPLAY_LINE_SYNC_OUT(dsync), .COMPOSITE_SYNC_OUT(csync), .FRAME_SYNC_OUT(fso),
    .CLAMP_WINDOW_OUT(clw), .LOCK_OUT(lock), .PIXEL_CLOCK_OUT(pclk),
    .SCAN_ACTIVE_OUT(scan)
  );

  sync_source u_sync_source (
    .clk_in(clk), .track_in(track), .pol_in(lpol), .level_in(lvl),
    .lag_in(lag), .disp_sync_in(dsync), .line_sync_out(ls)
  );

  // clock keeps running through every reset
  initial
  begin
    forever #50 clk = ~clk;
  end

  function automatic logic [31:0] lfsr(input logic [31:0] v);
    return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction

  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask

  // bounded wait; a lock that never comes shows up in the next compare
  task automatic wait_lock(input logic v, input int lim);
    for (int k = 0; k < lim && lock !== v; k++)
      @(posedge clk);
  endtask

  task automatic stop_test();
    if (n_mismatch == 0 && checks_done > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 30000)
    begin
      n_mismatch++;
      stop_test();
    end
  end

  initial
  begin
    int s;
    int tg;
    tick(20);
    arst_n <= 1'b1;
    tick(5);
    `CHK("lock at start", 1'b0, lock)
    // slots of 10 cycles let every pin settle through the synchroniser
    for (s = 0; s < 48; s++)
    begin
      rnd = lfsr(rnd);
      {fs, clamp, c1, ss, oe_n, lpol, fpol, div, csel, lvl, hold, mode} <= rnd[12:0];
      da <= rnd[31:8];
      db <= rnd[23:0];
      tg = 0;
      pp = pclk;
      repeat (10)
      begin
        @(posedge clk);
        tg += int'(pclk !== pp);
        pp = pclk;
      end
      ea = !oe_n && mode != 2'h2;
      eb = !oe_n && mode == 2'h1;
      `CHK("composite sync", csel ? ss : c1, csync)
      `CHK("frame sync", fs ~^ fpol, fso)
      `CHK("clamp window", clamp, clw)
      `CHK("scan active", 1'b0, scan)
      `CHK("pixel clock runs", 1'b1, tg > 0)
      `CHK("bus a enable", ea, ba.oe)
      `CHK("bus b enable", eb, bb.oe)
      if (ea)
        `CHK("bus a data", da, ba.data)
      if (eb)
        `CHK("bus b data", db, bb.data)
      if (!div)
        `CHK("line sync copy", lvl ~^ lpol, dsync)
    end
    track <= 1'b1;
    div <= 1'b1;
    hold <= 1'b0;
    lpol <= 1'b1;
    lag <= 10'd0;
    wait_lock(1'b1, 8000);
    `CHK("lock aligned", 1'b1, lock)
    lag <= 10'd100;
    wait_lock(1'b0, 1400);
    `CHK("lock lost", 1'b0, lock)
    lpol <= 1'b0;
    lag <= 10'd0;
    wait_lock(1'b1, 8000);
    `CHK("lock low polarity", 1'b1, lock)
    oe_n <= 1'b0;
    mode <= 2'h1;
    csel <= 1'b0;
    c1 <= 1'b1;
    tick(8);
    `CHK("bus b before reset", 1'b1, bb.oe)
    chip_rst_n <= 1'b0;
    tick(5);
    `CHK("lock in reset", 1'b0, lock)
    `CHK("bus a in reset", 1'b0, ba.oe)
    `CHK("bus b in reset", 1'b0, bb.oe)
    `CHK("csync in reset", 1'b0, csync)
    chip_rst_n <= 1'b1;
    wait_lock(1'b1, 8000);
    `CHK("relock", 1'b1, lock)
    // misaligned edges while frozen must not disturb the loop
    hold <= 1'b1;
    tick(4);
    lag <= 10'd100;
    tg = 0;
    repeat (2000)
    begin
      @(posedge clk);
      tg += int'(lock !== 1'b1);
    end
    `CHK("lock while frozen", 0, tg)
    hold <= 1'b0;
    wait_lock(1'b0, 1400);
    `CHK("lock after release", 1'b0, lock)
    stop_test();
  end
endmodule
